// File: rtl/adv_register.sv
// Purpose: Local advertisement register with its fixed and writable bits.
// Assumes: wr_en is a one-cycle pulse carrying a full 16-bit word.
// Notes:   Only the writable bits are stored; the rest are constants.
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_defs.svh"

module adv_register (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] adv_word
);

  logic [15:0] stored;

  // Writable flags: next page, fault, four abilities; rest masked off
  always_ff @(posedge clk) begin
    if (srst) begin
      stored <= `ADV_RESET & `ADV_WR_MASK;
    end else if (wr_en) begin
      stored <= wr_data & `ADV_WR_MASK;
    end
  end

  // T4 and reserved bits read 0, selector is the fixed 802.3 code
  assign adv_word = stored | {11'h000, `ADV_SELECTOR};

endmodule
`default_nettype wire

// File: rtl/partner_page_latch.sv
// Purpose: Holds the link partner base page once negotiation delivers it.
// Assumes: page_valid pulses once per accepted base page.
// Notes:   A page arriving with a restart wins, so no page is lost.
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_defs.svh"

module partner_page_latch (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        page_valid,
  input  wire logic [15:0] page_word,
  input  wire logic        neg_restart,
  output logic      [15:0] lp_word
);

  // Load on a valid page, clear on restart, hold otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      lp_word <= `LP_RESET;
    end else if (page_valid) begin
      lp_word <= page_word & `LP_KEEP_MASK;
    end else if (neg_restart) begin
      lp_word <= `LP_RESET;
    end
  end

endmodule
`default_nettype wire

// File: rtl/phy_id_autoneg_ability_regs.sv
// Purpose: Identifier and auto-negotiation ability registers behind the
//          serial management pins.
// Assumes: mdc and mdio_in are synchronous to clk and much slower than it.
// Notes:   Reads of unimplemented addresses return zero; writes to them and
//          to read-only registers are dropped.
//          Frames for another PHY address, or with an opcode other than read
//          or write, are dropped after the register address field.
//          Every frame needs its own preamble of 32 ones; a short one is lost.
//          Each mdc phase must last one clk cycle or more, or edges are missed.
//          A write lands one clk after its 16th data bit; the registered
//          ability ports follow one clk later.
`timescale 1ns/1ps
`default_nettype none
`include "phy_regs_defs.svh"

module phy_id_autoneg_ability_regs #(
  parameter logic [4:0]  PHY_ADDR     = 5'h01,
  parameter logic [15:0] ID_HIGH_WORD = 16'h1234, // Arbitrary value
  parameter logic [5:0]  OUI_TAIL     = 6'h2A,    // Arbitrary value
  parameter logic [5:0]  MODEL_NUMBER = 6'h11,    // Arbitrary value
  parameter logic [3:0]  REVISION     = 4'h3      // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe_n,
  input  wire logic        page_valid,
  input  wire logic [15:0] page_word,
  input  wire logic        neg_restart,
  output logic      [15:0] adv_ability,
  output logic      [15:0] lp_ability
);

  phy_regs_pkg::frame_state_t state;

  logic        mdc_q;
  logic [5:0]  pre_cnt;
  logic [4:0]  bit_cnt;
  logic [1:0]  opcode;
  logic [4:0]  phy_sel;
  logic [4:0]  reg_sel;
  logic [15:0] shift;
  logic        reading;
  logic        wr_pulse;
  logic [15:0] rd_data;
  logic [15:0] next_rd_data;
  logic [15:0] adv_word;
  logic [15:0] lp_word;

  // Edges of the management clock, seen in the system clock domain
  wire mdc_rise = mdc & ~mdc_q;
  wire mdc_fall = ~mdc & mdc_q;

  // Frame decode terms
  wire pre_done   = (pre_cnt == `PREAMBLE_LEN);
  wire last_bit_op   = (bit_cnt == `OP_BITS);
  wire last_bit_addr = (bit_cnt == `ADDR_BITS);
  wire last_bit_ta   = (bit_cnt == `TA_BITS);
  wire last_bit_data = (bit_cnt == `DATA_BITS);
  wire [4:0] reg_full = {reg_sel[3:0], mdio_in};
  wire addr_match    = (phy_sel == PHY_ADDR);
  wire op_valid      = (opcode == `OP_READ) || (opcode == `OP_WRITE);
  wire [15:0] wr_word = {shift[14:0], mdio_in};

  // Register hits, one named wire per implemented address
  wire hit_id_high = (reg_sel == `REG_PHY_IDENTIFIER_HIGH);
  wire hit_id_low  = (reg_sel == `REG_PHY_IDENTIFIER_LOW);
  wire hit_adv     = (reg_sel == `REG_AUTONEG_ADVERTISEMENT);
  wire hit_lp      = (reg_sel == `REG_LINK_PARTNER_ABILITY);

  // Write strobe; read-only and unmapped addresses never see it
  wire adv_wr = wr_pulse & hit_adv;

  // Field capture strobes, one per frame field, all on a management clock rise
  wire take_op   = mdc_rise && (state == phy_regs_pkg::FR_OPCODE);
  wire take_phy  = mdc_rise && (state == phy_regs_pkg::FR_PHYAD);
  wire take_reg  = mdc_rise && (state == phy_regs_pkg::FR_REGAD);
  wire load_rd   = mdc_rise && (state == phy_regs_pkg::FR_TURN) && last_bit_ta;
  wire take_data = mdc_rise && (state == phy_regs_pkg::FR_DATA);

  // Pin driver decode: turnaround zero first, then the data bits of a read
  wire drive_ta   = reading && (state == phy_regs_pkg::FR_TURN) && (bit_cnt == `TA_BITS);
  wire drive_data = reading && (state == phy_regs_pkg::FR_DATA);

  // Field bit counter step: back to zero on the last bit of each field
  function automatic logic [4:0] count_step(input logic       last,
                                            input logic [4:0] cnt);
    if (last) begin
      return 5'h00;
    end
    return cnt + 5'h01;
  endfunction

  // Fixed identifier low word
  wire [15:0] id_low_word = {OUI_TAIL, MODEL_NUMBER, REVISION};

  // Writable advertisement flags
  adv_register u_adv (
    .clk      (clk),
    .srst     (srst),
    .wr_en    (adv_wr),
    .wr_data  (shift),
    .adv_word (adv_word)
  );

  // Partner base page holder
  partner_page_latch u_lp (
    .clk         (clk),
    .srst        (srst),
    .page_valid  (page_valid),
    .page_word   (page_word),
    .neg_restart (neg_restart),
    .lp_word     (lp_word)
  );

  // Read selection; unimplemented addresses answer zero
  always_comb begin
    if (hit_id_high) begin
      next_rd_data = ID_HIGH_WORD;
    end else if (hit_id_low) begin
      next_rd_data = id_low_word;
    end else if (hit_adv) begin
      next_rd_data = adv_word;
    end else if (hit_lp) begin
      next_rd_data = lp_word;
    end else begin
      next_rd_data = 16'h0000;
    end
  end

  // Read word is captured every cycle; it is stable long before turnaround
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // Registered copies of the ability words for the negotiation engine
  always_ff @(posedge clk) begin
    if (srst) begin
      adv_ability <= `ADV_RESET;
      lp_ability  <= `LP_RESET;
    end else begin
      adv_ability <= adv_word;
      lp_ability  <= lp_word;
    end
  end

  // Previous management clock level for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= mdc;
    end
  end

  // Address and opcode fields shift in MSB first, one bit per rise
  always_ff @(posedge clk) begin
    if (srst) begin
      opcode  <= 2'h0;
      phy_sel <= 5'h00;
      reg_sel <= 5'h00;
    end else begin
      if (take_op) begin
        opcode <= {opcode[0], mdio_in};
      end
      if (take_phy) begin
        phy_sel <= {phy_sel[3:0], mdio_in};
      end
      if (take_reg) begin
        reg_sel <= reg_full;
      end
    end
  end

  // Data shifter: a read word loads at turnaround and leaves MSB first,
  // while a write word fills it from the pin over the same 16 rises
  always_ff @(posedge clk) begin
    if (srst) begin
      shift <= 16'h0000;
    end else if (load_rd) begin
      shift <= rd_data;
    end else if (take_data) begin
      shift <= wr_word;
    end
  end

  // Frame sequencer: counts the bits of each field on rising mdc edges
  always_ff @(posedge clk) begin
    if (srst) begin
      state    <= phy_regs_pkg::FR_IDLE;
      pre_cnt  <= 6'h00;
      bit_cnt  <= 5'h00;
      reading  <= 1'b0;
      wr_pulse <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      if (mdc_rise) begin
        case (state)
          phy_regs_pkg::FR_IDLE: begin
            // Count ones; a zero after a full preamble opens the frame
            if (mdio_in) begin
              if (!pre_done) begin
                pre_cnt <= pre_cnt + 6'h01;
              end
            end else if (pre_done) begin
              state <= phy_regs_pkg::FR_START;
            end else begin
              pre_cnt <= 6'h00;
            end
          end
          phy_regs_pkg::FR_START: begin
            // Second start bit must be a one, else hunt again
            bit_cnt <= 5'h00;
            pre_cnt <= 6'h00;
            if (mdio_in) begin
              state <= phy_regs_pkg::FR_OPCODE;
            end else begin
              state <= phy_regs_pkg::FR_IDLE;
            end
          end
          phy_regs_pkg::FR_OPCODE: begin
            // Two opcode bits
            bit_cnt <= count_step(last_bit_op, bit_cnt);
            if (last_bit_op) begin
              state <= phy_regs_pkg::FR_PHYAD;
            end
          end
          phy_regs_pkg::FR_PHYAD: begin
            // Five PHY address bits
            bit_cnt <= count_step(last_bit_addr, bit_cnt);
            if (last_bit_addr) begin
              state <= phy_regs_pkg::FR_REGAD;
            end
          end
          phy_regs_pkg::FR_REGAD: begin
            // Five register address bits, then accept or drop the frame
            bit_cnt <= count_step(last_bit_addr, bit_cnt);
            if (last_bit_addr) begin
              // Frames for another address or a bad opcode are ignored
              if (addr_match && op_valid) begin
                state   <= phy_regs_pkg::FR_TURN;
                reading <= (opcode == `OP_READ);
              end else begin
                state <= phy_regs_pkg::FR_IDLE;
              end
            end
          end
          phy_regs_pkg::FR_TURN: begin
            // Two turnaround bits; the read word loads on the second
            bit_cnt <= count_step(last_bit_ta, bit_cnt);
            if (last_bit_ta) begin
              state <= phy_regs_pkg::FR_DATA;
            end
          end
          phy_regs_pkg::FR_DATA: begin
            // Sixteen data bits, either direction
            bit_cnt <= count_step(last_bit_data, bit_cnt);
            if (last_bit_data) begin
              state    <= phy_regs_pkg::FR_IDLE;
              wr_pulse <= ~reading; // Write lands only after all 16 bits
            end
          end
          default: begin
            state <= phy_regs_pkg::FR_IDLE;
          end
        endcase
      end
    end
  end

  // Pin driver changes on falling edges so the host samples stable data;
  // it drives the turnaround zero, then data MSB first, then lets go
  always_ff @(posedge clk) begin
    if (srst) begin
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (mdc_fall) begin
      if (drive_ta) begin
        mdio_out  <= 1'b0;
        mdio_oe_n <= 1'b0;
      end else if (drive_data) begin
        mdio_out  <= shift[15];
        mdio_oe_n <= 1'b0;
      end else begin
        mdio_out  <= 1'b1;
        mdio_oe_n <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/phy_regs_defs.svh
// Purpose: Offsets, field positions, reset values and frame counts for the
//          identifier and auto-negotiation ability register bank.
// Assumes: Management frames use the usual clause-22 serial layout.
// Notes:   Definitions only; included by bare name.
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

// Register offsets on the management bus
`define REG_PHY_IDENTIFIER_HIGH   5'h02
`define REG_PHY_IDENTIFIER_LOW    5'h03
`define REG_AUTONEG_ADVERTISEMENT 5'h04
`define REG_LINK_PARTNER_ABILITY  5'h05

// Identifier low word layout
`define ID_OUI_MSB   15
`define ID_OUI_LSB   10
`define ID_MODEL_MSB 9
`define ID_MODEL_LSB 4
`define ID_REV_MSB   3
`define ID_REV_LSB   0

// Ability word bit positions (shared by advertisement and partner words)
`define ABIL_NEXT_PAGE    15
`define ABIL_ACK          14
`define ABIL_REMOTE_FAULT 13
`define ABIL_T4           9
`define ABIL_TX_FD        8
`define ABIL_TX_HD        7
`define ABIL_10_FD        6
`define ABIL_10_HD        5
`define ABIL_SEL_MSB      4
`define ABIL_SEL_LSB      0

// Reset values and masks
`define ADV_RESET    16'h01E1
`define ADV_WR_MASK  16'hA1E0
`define ADV_SELECTOR 5'h01
`define LP_RESET     16'h0000
`define LP_KEEP_MASK 16'hA1FF

// Frame layout
`define PREAMBLE_LEN 6'h20
`define OP_READ      2'h2
`define OP_WRITE     2'h1
`define OP_BITS      5'h01
`define ADDR_BITS    5'h04
`define TA_BITS      5'h01
`define DATA_BITS    5'h0F

`endif

// File: rtl/phy_regs_pkg.sv
// Purpose: Types for the management register bank.
// Assumes: Constants live in phy_regs_defs.svh.
// Notes:   Frame states are Gray coded from FR_IDLE to FR_DATA; FR_DATA back to FR_IDLE flips two bits.
`default_nettype none
package phy_regs_pkg;

  typedef enum logic [2:0] {
    FR_IDLE   = 3'h0,
    FR_START  = 3'h1,
    FR_OPCODE = 3'h3,
    FR_PHYAD  = 3'h2,
    FR_REGAD  = 3'h6,
    FR_TURN   = 3'h7,
    FR_DATA   = 3'h5
  } frame_state_t;

endpackage
`default_nettype wire

// File: tb/phy_id_autoneg_ability_regs_test.sv
// Purpose: Self-checking bench for the identifier and ability registers.
// Assumes: Default PHY address and identity parameters.
// Notes:   Frames come from the station model; pages are driven here.
`timescale 1ns/1ps
`default_nettype none
module phy_id_autoneg_ability_regs_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        mdc;
  logic        m_val;
  logic        m_en;
  logic        page_valid = 1'b0;
  logic        neg_restart = 1'b0;
  logic [15:0] page_word = 16'h0000;
  logic [15:0] adv_ability;
  logic [15:0] lp_ability;
  logic [15:0] rd;
  logic        mdio_out;
  logic        mdio_oe_n;
  wire         mdio_w;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  localparam logic [15:0] ID_LOW = {6'h2A, 6'h11, 4'h3};

  always #10 clk = ~clk;
  // Released line floats to the pull-up level
  assign mdio_w = !mdio_oe_n ? mdio_out : (m_en ? m_val : 1'b1);

  phy_id_autoneg_ability_regs u_phy_id_autoneg_ability_regs (
    .clk(clk), .srst(srst), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .page_valid(page_valid), .page_word(page_word),
    .neg_restart(neg_restart), .adv_ability(adv_ability), .lp_ability(lp_ability));
  sta_model u_sta_model (.clk(clk), .mdio(mdio_w), .mdc(mdc), .m_val(m_val), .m_en(m_en));

  // A run needs about 10000 cycles; a hung frame stops here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
    u_sta_model.frame(2'h2, 5'h01, ra, 16'h0000, d);
  endtask
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    u_sta_model.frame(2'h1, 5'h01, ra, d, x);
  endtask
  // Another PHY address or a bad opcode must leave line and registers alone
  task automatic t_refused();
    u_sta_model.frame(2'h1, 5'h02, 5'h04, 16'h0000, rd);
    u_sta_model.frame(2'h3, 5'h01, 5'h04, 16'h0000, rd);
    u_sta_model.frame(2'h2, 5'h02, 5'h04, 16'h0000, rd);
    chk("other phy read", rd, 16'hFFFF);
    rd_reg(5'h04, rd);
    chk("adv kept", rd, 16'h01E1);
    $display("t_refused done");
  endtask
  // Page word is scrambled after the pulse to catch a latch that follows it
  task automatic pulse(input logic pv, input logic nr, input logic [15:0] w);
    @(negedge clk);
    page_valid = pv;
    neg_restart = nr;
    page_word = w;
    @(negedge clk);
    page_valid = 1'b0;
    neg_restart = 1'b0;
    page_word = ~w;
  endtask

  task automatic t_reset_values();
    logic [15:0] exp [4];
    exp = '{16'h1234, ID_LOW, 16'h01E1, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      rd_reg(5'(i + 2), rd);
      chk("reset word", rd, exp[i]);
    end
    rd_reg(5'h1F, rd);
    chk("unmapped", rd, 16'h0000);
    $display("t_reset_values done");
  endtask
  task automatic t_adv_write();
    wr_reg(5'h04, 16'hFFFF);
    rd_reg(5'h04, rd);
    chk("adv ones", rd, 16'hA1E1);
    chk("adv port", adv_ability, 16'hA1E1);
    wr_reg(5'h04, 16'h0000);
    rd_reg(5'h04, rd);
    chk("adv zeros", rd, 16'h0001);
    $display("t_adv_write done");
  endtask
  task automatic t_read_only();
    wr_reg(5'h03, 16'h0000);
    wr_reg(5'h05, 16'hFFFF);
    rd_reg(5'h03, rd);
    chk("id low kept", rd, ID_LOW);
    rd_reg(5'h05, rd);
    chk("lp kept", rd, 16'h0000);
    $display("t_read_only done");
  endtask
  task automatic t_partner();
    pulse(1'b1, 1'b0, 16'hFFFF);
    rd_reg(5'h05, rd);
    chk("lp page", rd, 16'hA1FF);
    chk("lp port", lp_ability, 16'hA1FF);
    pulse(1'b1, 1'b1, 16'h0021);
    rd_reg(5'h05, rd);
    chk("lp page wins", rd, 16'h0021);
    pulse(1'b0, 1'b1, 16'hFFFF);
    rd_reg(5'h05, rd);
    chk("lp restart", rd, 16'h0000);
    $display("t_partner done");
  endtask
  task automatic t_second_reset();
    wr_reg(5'h04, 16'h0000);
    pulse(1'b1, 1'b0, 16'hA020);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("adv after reset", adv_ability, 16'h01E1);
    chk("lp after reset", lp_ability, 16'h0000);
    $display("t_second_reset done");
  endtask

  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    t_reset_values();
    t_refused();
    t_adv_write();
    t_read_only();
    t_partner();
    t_second_reset();
    give_verdict();
  end
endmodule

bind phy_id_autoneg_ability_regs phy_regs_asserts u_phy_regs_asserts (
  .clk(clk), .srst(srst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
  .mdio_oe_n(mdio_oe_n), .page_valid(page_valid), .page_word(page_word),
  .neg_restart(neg_restart), .adv_ability(adv_ability), .lp_ability(lp_ability));
`default_nettype wire

// File: tb/phy_regs_asserts.sv
// Purpose: Port checks for the identifier and ability registers.
// Assumes: One clk domain; srst synchronous, active high.
// Notes:   Bound to the register block from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module phy_regs_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        mdc,
  input wire logic        mdio_in,
  input wire logic        mdio_out,
  input wire logic        mdio_oe_n,
  input wire logic        page_valid,
  input wire logic [15:0] page_word,
  input wire logic        neg_restart,
  input wire logic [15:0] adv_ability,
  input wire logic [15:0] lp_ability
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Constant bits of both ability words
  a_adv_fixed_bits: assert property ((adv_ability & 16'h5E1F) == 16'h0001)
    else $error("adv constant bits");
  a_lp_zero_bits: assert property ((lp_ability & 16'h5E00) == 16'h0000)
    else $error("lp constant bits");
  a_reset_values: assert property ($fell(srst) |->
    adv_ability == 16'h01E1 && lp_ability == 16'h0000)
    else $error("reset values");
  // Port copy lags the latch by one cycle
  a_lp_page_load: assert property (page_valid |->
    ##2 lp_ability == ($past(page_word, 2) & 16'hA1FF))
    else $error("lp page load");
  a_lp_holds: assert property ((!page_valid && !neg_restart) ##1 1'b1 |=>
    $stable(lp_ability))
    else $error("lp hold");
  a_restart_clear: assert property (neg_restart && !page_valid |->
    ##2 lp_ability == 16'h0000)
    else $error("lp restart");
  // Data pin moves only in the mdc low phase, so the master sees it settled
  a_out_still_high: assert property (mdc && $past(mdc) |-> $stable({mdio_out, mdio_oe_n}))
    else $error("mdio moved in high phase");
  a_idle_level: assert property (mdio_oe_n |-> mdio_out)
    else $error("released level");

  c_page: cover property (page_valid);
  c_restart: cover property (neg_restart);
  c_drive: cover property ($fell(mdio_oe_n));
endmodule
`default_nettype wire

// File: tb/sta_model.sv
// Purpose: Station management model sending clause-22 frames.
// Assumes: mdc low phases of three clk cycles, high phases of four; mdc idles low.
// Notes:   Releases the data line from the read turnaround on.
`timescale 1ns/1ps
`default_nettype none
module sta_model (
  input  wire logic clk,
  input  wire logic mdio,
  output logic      mdc,
  output logic      m_val,
  output logic      m_en
);
  // Idle: clock still, line released
  initial begin
    mdc = 1'b0;
    m_val = 1'b1;
    m_en = 1'b0;
  end
  // One bit: set in the low phase, taken at the rise
  task automatic bit_cyc(input logic b, input logic en, output logic s);
    @(negedge clk);
    mdc = 1'b0;
    m_val = b;
    m_en = en;
    repeat (3) @(negedge clk);
    mdc = 1'b1;
    s = mdio;
    repeat (3) @(negedge clk);
  endtask
  // Frame with a fresh preamble, since the count restarts per frame
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic        s;
    logic        wr;
    logic [45:0] hdr;
    wr = (op == 2'h1);
    hdr = {32'hFFFFFFFF, 2'h1, op, pa, ra};
    for (int i = 45; i >= 0; i--)
      bit_cyc(hdr[i], 1'b1, s);
    bit_cyc(1'b1, wr, s);
    bit_cyc(1'b0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], wr, s);
      rd[i] = s;
    end
    @(negedge clk);
    mdc = 1'b0;
    m_en = 1'b0;
    repeat (3) @(negedge clk);
  endtask
endmodule
`default_nettype wire
